//--- inc/tws_pkg.sv
// constants, states and commands shared by both ends of the two-wire link
// assumes: mclk at 40 MHz on the master end; the slave link logic runs on scl, its user side on mclk
`default_nettype none

package tws_pkg;

   localparam int unsigned MCLK_HZ     = 40_000_000;
   localparam int unsigned SCL_STD_HZ  = 100_000;
   localparam int unsigned SCL_FAST_HZ = 400_000;
   // quarter bit periods in mclk cycles, rounded up so scl never runs fast
   localparam int unsigned QTR_STD  = (MCLK_HZ + 4 * SCL_STD_HZ - 1) / (4 * SCL_STD_HZ);
   localparam int unsigned QTR_FAST = (MCLK_HZ + 4 * SCL_FAST_HZ - 1) / (4 * SCL_FAST_HZ);

   localparam logic [6:0] DIAG_ADDR = 7'h50;
   localparam logic [3:0] ACK_SLOT  = 4'h8;
   localparam logic [3:0] CNT_RST   = 4'h0;
   localparam logic [3:0] CNT_FIRST = 4'h1;

   // quarters of one bit period on the master end
   localparam logic [1:0] PH_SETUP = 2'h0;
   localparam logic [1:0] PH_RISE  = 2'h1;
   localparam logic [1:0] PH_HIGH  = 2'h2;
   localparam logic [1:0] PH_FALL  = 2'h3;

   typedef enum logic [3:0] {
      DS_IDLE = 4'h1,
      DS_ADDR = 4'h2,
      DS_WR   = 4'h4,
      DS_RD   = 4'h8
   } tws_dev_st_t;

   typedef enum logic [3:0] {
      HS_IDLE  = 4'h1,
      HS_START = 4'h2,
      HS_STOP  = 4'h4,
      HS_BIT   = 4'h8
   } tws_host_st_t;

   typedef enum logic [1:0] {
      OP_START = 2'h0,
      OP_STOP  = 2'h1,
      OP_WRITE = 2'h2,
      OP_READ  = 2'h3
   } tws_op_t;

endpackage : tws_pkg

`default_nettype wire

//--- inc/tws_link_if.sv
// open-drain two-wire link between the bus master and the slave end
// assumes: external pull-ups, so an undriven line reads high
`timescale 1ns/100ps
`default_nettype none

interface tws_link_if;

   logic scl_o;
   logic scl_oe_n;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;
   logic scl_i;
   logic sda_i;

   // wired-and with pull-up: low only while some party pulls the line
   assign scl_i = scl_oe_n | scl_o;
   assign sda_i = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

   modport host (
      output scl_o,
      output scl_oe_n,
      output host_sda_o,
      output host_sda_oe_n,
      input  scl_i,
      input  sda_i
   );

   modport dev (
      output dev_sda_o,
      output dev_sda_oe_n,
      input  scl_i,
      input  sda_i
   );

endinterface : tws_link_if

`default_nettype wire

//--- design/tws_host.sv
// bus master end: makes scl by dividing mclk, runs start, stop and byte commands
// assumes: one command at a time on a valid/ready port; link via tws_link_if
`timescale 1ns/100ps
`default_nettype none

module tws_host
   import tws_pkg::*;
#(
   parameter int unsigned QTR_S = QTR_STD,
   parameter int unsigned QTR_F = QTR_FAST
) (
   tws_link_if.host        link,
   input  wire logic       mclk,
   input  wire logic       resetn,
   input  wire logic       fast,
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   input  wire tws_op_t    cmd_op,
   input  wire logic [7:0] cmd_data,
   input  wire logic       cmd_last,
   output logic            done,
   output logic [7:0]      rd_data,
   output logic            ack_seen
);

   generate
      if (QTR_S < 2 || QTR_F < 2 || QTR_S > 65535 || QTR_F > 65535) begin : g_bad_qtr
         $error("tws_host: quarter period must lie in 2..65535");
      end
   endgenerate

   tws_host_st_t state_ff;
   logic [15:0]  qcnt_ff;
   logic [1:0]   ph_ff;
   logic [3:0]   bit_ff;
   logic [8:0]   sh_ff;
   logic [8:0]   rx_ff;
   logic         scl_drv_ff;
   logic         sda_drv_ff;
   logic [1:0]   scl_s_ff;
   logic [1:0]   sda_s_ff;
   logic         done_ff;
   logic [7:0]   rd_data_ff;
   logic         ack_seen_ff;
   logic [15:0]  qlen;
   logic         tick;
   logic         hold;
   logic         adv;
   logic         fin;
   logic         accept;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and quarter-period divider
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         scl_s_ff <= 2'h3;
         sda_s_ff <= 2'h3;
      end else begin
         scl_s_ff <= {scl_s_ff[0], link.scl_i};
         sda_s_ff <= {sda_s_ff[0], link.sda_i};
      end
   end

   assign qlen   = fast ? 16'(QTR_F) : 16'(QTR_S);
   assign tick   = (state_ff != HS_IDLE) && (qcnt_ff == 16'h0);
   // start waits for a free bus, every bit waits for scl really high
   assign hold   = ((state_ff == HS_START) && !(scl_s_ff[1] && sda_s_ff[1]))
                || ((state_ff == HS_BIT) && !scl_s_ff[1]);
   assign adv    = tick && !((ph_ff == PH_HIGH) && hold);
   assign fin    = adv && (ph_ff == PH_FALL) && ((state_ff != HS_BIT) || (bit_ff == ACK_SLOT));
   assign accept = (state_ff == HS_IDLE) && cmd_valid;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         qcnt_ff <= 16'h0;
      end else if (state_ff == HS_IDLE || tick) begin
         qcnt_ff <= qlen - 16'h1;
      end else begin
         qcnt_ff <= qcnt_ff - 16'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command sequencing
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= HS_IDLE;
      end else begin
         case (state_ff)
            HS_IDLE: begin
               if (cmd_valid) begin
                  case (cmd_op)
                     OP_START: state_ff <= HS_START;
                     OP_STOP:  state_ff <= HS_STOP;
                     default:  state_ff <= HS_BIT;
                  endcase
               end
            end
            HS_START, HS_STOP, HS_BIT: begin
               if (fin) begin
                  state_ff <= HS_IDLE;
               end
            end
            default: state_ff <= HS_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ph_ff  <= PH_SETUP;
         bit_ff <= CNT_RST;
      end else if (state_ff == HS_IDLE) begin
         ph_ff  <= PH_SETUP;
         bit_ff <= CNT_RST;
      end else if (adv) begin
         ph_ff <= ph_ff + 2'h1;
         if (ph_ff == PH_FALL) begin
            bit_ff <= bit_ff + 4'h1;
         end
      end
   end

   // nine slots per byte: eight data bits then the acknowledge slot
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sh_ff <= 9'h1ff;
         rx_ff <= 9'h0;
      end else if (accept) begin
         // reading: release for data, acknowledge all but the last byte
         sh_ff <= (cmd_op == OP_WRITE) ? {cmd_data, 1'b1} : {8'hff, cmd_last};
      end else if (state_ff == HS_BIT && adv) begin
         if (ph_ff == PH_HIGH) begin
            rx_ff <= {rx_ff[7:0], sda_s_ff[1]};
         end
         if (ph_ff == PH_FALL) begin
            sh_ff <= {sh_ff[7:0], 1'b1};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // line drivers: sda moves only with scl low, except for start and stop
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         scl_drv_ff <= 1'b0;
      end else if (adv && ph_ff == PH_RISE) begin
         scl_drv_ff <= 1'b0;
      end else if (adv && ph_ff == PH_FALL && state_ff != HS_STOP) begin
         scl_drv_ff <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sda_drv_ff <= 1'b0;
      end else if (adv && ph_ff == PH_SETUP) begin
         case (state_ff)
            HS_START: sda_drv_ff <= 1'b0;
            HS_STOP:  sda_drv_ff <= 1'b1;
            default:  sda_drv_ff <= !sh_ff[8];
         endcase
      end else if (adv && ph_ff == PH_HIGH) begin
         case (state_ff)
            HS_START: sda_drv_ff <= 1'b1;
            HS_STOP:  sda_drv_ff <= 1'b0;
            default:  sda_drv_ff <= sda_drv_ff;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         done_ff     <= 1'b0;
         rd_data_ff  <= 8'h0;
         ack_seen_ff <= 1'b0;
      end else begin
         done_ff <= fin;
         if (fin && state_ff == HS_BIT) begin
            rd_data_ff  <= rx_ff[8:1];
            ack_seen_ff <= !rx_ff[0];
         end
      end
   end

   assign cmd_ready          = (state_ff == HS_IDLE);
   assign done               = done_ff;
   assign rd_data            = rd_data_ff;
   assign ack_seen           = ack_seen_ff;
   assign link.scl_o         = 1'b0;
   assign link.scl_oe_n      = !scl_drv_ff;
   assign link.host_sda_o    = 1'b0;
   assign link.host_sda_oe_n = !sda_drv_ff;

endmodule : tws_host

`default_nettype wire

//--- design/tws_dev.sv
// slave end: two-wire protocol engine of the diagnostics_controller
// assumes: scl and sda resolved by tws_link_if; link logic clocked by scl
// and by sda edges; user side on mclk; tx_data held stable after tx_req
//
// Summary of operation
// - master starts only while bus idle
// - sda change with scl high is control
// - idle is both high; release unused lines
// - sda fall, scl high: start, restart addressing
// - sda rise, scl high: stop ends transfer
// - one bit per scl pulse, sampled high
// - any byte count between start and stop
// - eight bits then receiver's acknowledge bit
// - works at standard and fast scl
// - master gives ninth pulse for acknowledge
// - acknowledger holds sda low through pulse
// - master nacks last byte it reads
// - on master nack, release sda
// - acknowledge control byte and every written byte
// - stop or repeated start ends transfer
// - read direction: transmit after acknowledging address
// - compare address after eight bits, before acknowledge
// - upper seven bits must match device address
// - low bit one reads, zero writes
// - acknowledge matching address on ninth clock
// - no acknowledge while nonvolatile write busy
`timescale 1ns/100ps
`default_nettype none

module tws_dev
   import tws_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DIAG_ADDR
) (
   tws_link_if.dev         link,
   input  wire logic       mclk,
   input  wire logic       resetn,
   input  wire logic       nvm_busy,
   input  wire logic [7:0] tx_data,
   output logic            tx_req,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic            start_seen,
   output logic            stop_seen
);

   generate
      if (DEV_ADDR == 7'h00) begin : g_bad_addr
         $error("tws_dev: address zero is the broadcast address");
      end
   endgenerate

   localparam int NEVT = 4;

   logic              start_tgl_ff;
   logic              stop_tgl_ff;
   logic              start_ack_ff;
   tws_dev_st_t       state_ff;
   logic [3:0]        cnt_ff;
   logic [7:0]        sh_ff;
   logic [7:0]        tx_ff;
   logic [7:0]        rx_byte_ff;
   logic              rx_tgl_ff;
   logic              txq_tgl_ff;
   logic              busy_s1_ff;
   logic              busy_s2_ff;
   logic              drv_ff;
   logic              start_new;
   logic              byte_end;
   logic              load_tx;
   logic              addr_hit;
   logic [NEVT-1:0]   tgl_in;
   logic [NEVT-1:0]   s1_ff;
   logic [NEVT-1:0]   s2_ff;
   logic [NEVT-1:0]   s3_ff;
   logic [NEVT-1:0]   evt_ff;
   logic [7:0]        rx_data_ff;

   ////////////////////////////////////////////////////////////////////////
   // bus conditions: sda edges while scl is high
   always_ff @(negedge link.sda_i or negedge resetn) begin
      if (!resetn) begin
         start_tgl_ff <= 1'b0;
      end else if (link.scl_i) begin
         start_tgl_ff <= ~start_tgl_ff;
      end
   end

   always_ff @(posedge link.sda_i or negedge resetn) begin
      if (!resetn) begin
         stop_tgl_ff <= 1'b0;
      end else if (link.scl_i) begin
         stop_tgl_ff <= ~stop_tgl_ff;
      end
   end

   // a start seen since the last scl rise; it changes only with scl high,
   // so it stands still for the whole low half before the next rise
   assign start_new = start_tgl_ff ^ start_ack_ff;
   assign byte_end  = !start_new && (cnt_ff == ACK_SLOT);
   assign addr_hit  = (sh_ff[7:1] == DEV_ADDR);
   assign load_tx   = byte_end && (((state_ff == DS_ADDR) && drv_ff && sh_ff[0])
                   || ((state_ff == DS_RD) && !link.sda_i));

   ////////////////////////////////////////////////////////////////////////
   // link domain, scl rising: sample, count, step state; any scl rate
   always_ff @(posedge link.scl_i or negedge resetn) begin
      if (!resetn) begin
         busy_s1_ff <= 1'b0;
         busy_s2_ff <= 1'b0;
      end else begin
         busy_s1_ff <= nvm_busy;
         busy_s2_ff <= busy_s1_ff;
      end
   end

   always_ff @(posedge link.scl_i or negedge resetn) begin
      if (!resetn) begin
         start_ack_ff <= 1'b0;
         state_ff     <= DS_IDLE;
         cnt_ff       <= CNT_RST;
      end else if (start_new) begin
         start_ack_ff <= start_tgl_ff;
         state_ff     <= DS_ADDR;
         cnt_ff       <= CNT_FIRST;
      end else begin
         cnt_ff <= (cnt_ff == ACK_SLOT) ? CNT_RST : cnt_ff + 4'h1;
         if (cnt_ff == ACK_SLOT) begin
            case (state_ff)
               // no acknowledge given: ignore the bus until a start
               DS_ADDR: state_ff <= !drv_ff ? DS_IDLE
                                   : (sh_ff[0] ? DS_RD : DS_WR);
               DS_WR:   state_ff <= drv_ff ? DS_WR : DS_IDLE;
               DS_RD:   state_ff <= link.sda_i ? DS_IDLE : DS_RD;
               default: state_ff <= DS_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge link.scl_i or negedge resetn) begin
      if (!resetn) begin
         sh_ff <= 8'h0;
      end else if (cnt_ff != ACK_SLOT || start_new) begin
         sh_ff <= {sh_ff[6:0], link.sda_i};
      end
   end

   always_ff @(posedge link.scl_i or negedge resetn) begin
      if (!resetn) begin
         rx_byte_ff <= 8'h0;
         rx_tgl_ff  <= 1'b0;
      end else if (byte_end && state_ff == DS_WR && drv_ff) begin
         rx_byte_ff <= sh_ff;
         rx_tgl_ff  <= ~rx_tgl_ff;
      end
   end

   always_ff @(posedge link.scl_i or negedge resetn) begin
      if (!resetn) begin
         tx_ff      <= 8'hff;
         txq_tgl_ff <= 1'b0;
      end else if (load_tx) begin
         tx_ff      <= tx_data;
         txq_tgl_ff <= ~txq_tgl_ff;
      end else if (state_ff == DS_RD) begin
         tx_ff <= {tx_ff[6:0], 1'b1};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // link domain, scl falling: sda changes only while scl is low
   always_ff @(negedge link.scl_i or negedge resetn) begin
      if (!resetn) begin
         drv_ff <= 1'b0;
      end else if (start_new) begin
         drv_ff <= 1'b0;
      end else begin
         case (state_ff)
            // address checked once all eight bits are in
            DS_ADDR: drv_ff <= (cnt_ff == ACK_SLOT) && addr_hit
                              && !busy_s2_ff;
            DS_WR:   drv_ff <= (cnt_ff == ACK_SLOT)
                              && !busy_s2_ff;
            DS_RD:   drv_ff <= (cnt_ff != ACK_SLOT) && !tx_ff[7];
            default: drv_ff <= 1'b0;
         endcase
      end
   end

   assign link.dev_sda_o    = 1'b0;
   assign link.dev_sda_oe_n = !drv_ff;

   ////////////////////////////////////////////////////////////////////////
   // event toggles into mclk: two flops, then an edge compare
   assign tgl_in = {txq_tgl_ff, rx_tgl_ff, stop_tgl_ff, start_tgl_ff};

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s1_ff  <= '0;
         s2_ff  <= '0;
         s3_ff  <= '0;
         evt_ff <= '0;
      end else begin
         s1_ff  <= tgl_in;
         s2_ff  <= s1_ff;
         s3_ff  <= s2_ff;
         evt_ff <= s2_ff ^ s3_ff;
      end
   end

   // the received byte stands still until the next byte completes
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rx_data_ff <= 8'h0;
      end else if (s2_ff[2] ^ s3_ff[2]) begin
         rx_data_ff <= rx_byte_ff;
      end
   end

   assign start_seen = evt_ff[0];
   assign stop_seen  = evt_ff[1];
   assign rx_valid   = evt_ff[2];
   assign tx_req     = evt_ff[3];
   assign rx_data    = rx_data_ff;

endmodule : tws_dev

`default_nettype wire

//--- dv/tws_link_sva.sv
// link checker: protocol relations on the resolved lines and the enables
// assumes: sampled on mclk; host quarters of at least 4 mclk cycles
`timescale 1ns/100ps
`default_nettype none

module tws_link_sva
   import tws_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic scl_oe_n,
   input wire logic host_sda_oe_n,
   input wire logic dev_sda_oe_n
);

   logic       scl_q_ff;
   logic       sda_q_ff;
   logic       first_ff;
   logic       miss_ff;
   logic       rd_ff;
   logic       nack_ff;
   logic [3:0] cnt_ff;
   logic [7:0] shift_ff;
   logic       start_ev;
   logic       rise;
   logic       slot9;

   ////////////////////////////////////////////////////////////////////////////////
   assign start_ev = scl_q_ff & scl_i & sda_q_ff & ~sda_i;
   assign rise     = ~scl_q_ff & scl_i;
   assign slot9    = rise & (cnt_ff == ACK_SLOT);

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end else begin
         scl_q_ff <= scl_i;
         sda_q_ff <= sda_i;
      end
   end

   // bit count, control byte, and when the slave must stay off sda
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cnt_ff   <= CNT_RST;
         shift_ff <= 8'h00;
         first_ff <= 1'b0;
         miss_ff  <= 1'b0;
         rd_ff    <= 1'b0;
         nack_ff  <= 1'b0;
      end else if (start_ev) begin
         cnt_ff   <= CNT_RST;
         first_ff <= 1'b1;
         miss_ff  <= 1'b0;
         rd_ff    <= 1'b0;
         nack_ff  <= 1'b0;
      end else if (slot9) begin
         cnt_ff   <= CNT_RST;
         first_ff <= 1'b0;
         if (first_ff) begin
            miss_ff <= dev_sda_oe_n;
            rd_ff   <= shift_ff[0];
         end else if (rd_ff && sda_i) begin
            nack_ff <= 1'b1;
         end
      end else if (rise) begin
         cnt_ff   <= cnt_ff + CNT_FIRST;
         shift_ff <= {shift_ff[6:0], sda_i};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   sequence s_stop;
      $rose(sda_i) && scl_i && $past(scl_i);
   endsequence
   sequence s_idle;
      (scl_i && sda_i)[*4];
   endsequence

   property p_rst_release;
      $rose(resetn) |-> scl_oe_n && host_sda_oe_n && dev_sda_oe_n;
   endproperty
   property p_dev_stable;
      scl_i && $past(scl_i) |-> $stable(dev_sda_oe_n);
   endproperty
   property p_stop_idle;
      s_stop |=> s_idle;
   endproperty
   property p_scl_high;
      $rose(scl_i) |-> scl_i[*4];
   endproperty
   property p_addr_quiet;
      first_ff && (cnt_ff < ACK_SLOT) |-> dev_sda_oe_n;
   endproperty
   property p_ack_match;
      slot9 && first_ff && !dev_sda_oe_n |-> shift_ff[7:1] == DIAG_ADDR;
   endproperty
   property p_silent;
      miss_ff |-> dev_sda_oe_n;
   endproperty
   property p_rd_slot;
      slot9 && !first_ff && rd_ff |-> dev_sda_oe_n;
   endproperty
   property p_nack;
      nack_ff |-> dev_sda_oe_n;
   endproperty

   a_rst_release: assert property (p_rst_release)
      else $error("line driven right after reset");
   a_dev_stable: assert property (p_dev_stable)
      else $error("slave sda moved while scl high");
   a_stop_idle: assert property (p_stop_idle)
      else $error("bus not idle after stop");
   a_scl_high: assert property (p_scl_high)
      else $error("scl high period too short");
   a_addr_quiet: assert property (p_addr_quiet)
      else $error("slave drove sda during control byte");
   a_ack_match: assert property (p_ack_match)
      else $error("acknowledge on foreign address");
   a_silent: assert property (p_silent)
      else $error("slave drove sda after no acknowledge");
   a_rd_slot: assert property (p_rd_slot)
      else $error("slave drove master acknowledge slot");
   a_nack: assert property (p_nack)
      else $error("slave drove sda after master nack");

endmodule : tws_link_sva

`default_nettype wire

//--- dv/two_wire_slave_protocol_bench.sv
// bench: bus master end and slave end joined on one link, user sides driven
// assumes: pull-ups in the link interface; short quarters keep the run brief
`timescale 1ns/100ps
`default_nettype none

module two_wire_slave_protocol_bench
   import tws_pkg::*;
;
   localparam logic [7:0] CTRL_WR = {DIAG_ADDR, 1'b0};
   localparam logic [7:0] CTRL_RD = {DIAG_ADDR, 1'b1};
   localparam logic [7:0] TBL [0:3] = '{8'h3c, 8'h81, 8'hff, 8'h00};
   localparam logic [7:0] BAD [0:2] = '{8'ha2, 8'h20, 8'hd1};

   logic       mclk;
   logic       resetn;
   logic       fast;
   logic       cmd_valid;
   logic       cmd_ready;
   tws_op_t    cmd_op;
   logic [7:0] cmd_data;
   logic       cmd_last;
   logic       done;
   logic [7:0] rd_data;
   logic       ack_seen;
   logic       nvm_busy;
   logic [7:0] tx_data;
   logic       tx_req;
   logic       rx_valid;
   logic [7:0] rx_data;
   logic       start_seen;
   logic       stop_seen;
   int         failures;
   int         num_checks;
   int         tx_idx;
   int         n_start;
   int         n_stop;
   int         s0;
   int         p0;
   logic [7:0] rxq [$];

   tws_link_if link ();
   tws_host #(.QTR_S(8), .QTR_F(4)) i_tws_host (
      .link(link), .mclk(mclk), .resetn(resetn), .fast(fast),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
      .cmd_data(cmd_data), .cmd_last(cmd_last), .done(done),
      .rd_data(rd_data), .ack_seen(ack_seen));
   tws_dev i_tws_dev (
      .link(link), .mclk(mclk), .resetn(resetn), .nvm_busy(nvm_busy),
      .tx_data(tx_data), .tx_req(tx_req), .rx_valid(rx_valid),
      .rx_data(rx_data), .start_seen(start_seen), .stop_seen(stop_seen));
   tws_link_sva i_tws_link_sva (
      .mclk(mclk), .resetn(resetn), .scl_i(link.scl_i), .sda_i(link.sda_i),
      .scl_oe_n(link.scl_oe_n), .host_sda_oe_n(link.host_sda_oe_n),
      .dev_sda_oe_n(link.dev_sda_oe_n));

   ////////////////////////////////////////////////////////////////////////////////
   assign tx_data = TBL[tx_idx[1:0]];

   always #12.5 mclk = ~mclk;

   always @(posedge mclk) begin
      if (rx_valid === 1'b1) rxq.push_back(rx_data);
      if (tx_req === 1'b1) tx_idx <= tx_idx + 1;
      if (start_seen === 1'b1) n_start <= n_start + 1;
      if (stop_seen === 1'b1) n_stop <= n_stop + 1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic host_op(input tws_op_t op, input logic [7:0] d, input logic lst);
      int n;
      n = 0;
      cmd_op    <= op;
      cmd_data  <= d;
      cmd_last  <= lst;
      cmd_valid <= 1'b1;
      do @(posedge mclk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      do begin
         @(posedge mclk);
         n++;
      end while (done !== 1'b1 && n < 2000);
      if (n >= 2000) check(8'h00, 8'h01);
   endtask : host_op

   task automatic wr_byte(input logic [7:0] d, input logic ack);
      host_op(OP_WRITE, d, 1'b0);
      check({7'h00, ack_seen}, {7'h00, ack});
   endtask : wr_byte

   task automatic rd_byte(input logic lst, input logic [7:0] exp);
      host_op(OP_READ, 8'h00, lst);
      check(rd_data, exp);
   endtask : rd_byte

   task automatic settle();
      repeat (8) @(posedge mclk);
   endtask : settle

   task final_report();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      // the whole sequence needs well under ten thousand cycles
      repeat (20000) @(posedge mclk);
      failures++;
      final_report();
   end

   initial begin
      mclk = 1'b0;
      resetn = 1'b0;
      fast = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = OP_START;
      cmd_data = 8'h00;
      cmd_last = 1'b0;
      nvm_busy = 1'b0;
      tx_idx = 0;
      failures = 0;
      num_checks = 0;
      n_start = 0;
      n_stop = 0;
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      // written bytes at both rates
      for (int f = 0; f < 2; f++) begin
         fast <= f[0];
         rxq.delete();
         host_op(OP_START, 8'h00, 1'b0);
         wr_byte(CTRL_WR, 1'b1);
         for (int i = 0; i < 4; i++) wr_byte(TBL[i], 1'b1);
         host_op(OP_STOP, 8'h00, 1'b0);
         settle();
         check(8'(rxq.size()), 8'h04);
         for (int i = 0; i < 4; i++) check(rxq[i], TBL[i]);
         $display("test write fast=%0d done", f);
      end
      // repeated start into a read, master nack on the last byte
      fast <= 1'b0;
      tx_idx <= 0;
      s0 = n_start;
      p0 = n_stop;
      host_op(OP_START, 8'h00, 1'b0);
      wr_byte(CTRL_WR, 1'b1);
      host_op(OP_START, 8'h00, 1'b0);
      wr_byte(CTRL_RD, 1'b1);
      rd_byte(1'b0, TBL[0]);
      rd_byte(1'b0, TBL[1]);
      rd_byte(1'b1, TBL[2]);
      host_op(OP_STOP, 8'h00, 1'b0);
      settle();
      check({7'h00, link.sda_i}, 8'h01);
      check(8'(n_start - s0), 8'h02);
      check(8'(n_stop - p0), 8'h01);
      $display("test read done");
      // foreign addresses stay unanswered
      rxq.delete();
      for (int i = 0; i < 3; i++) begin
         host_op(OP_START, 8'h00, 1'b0);
         wr_byte(BAD[i], 1'b0);
         wr_byte(8'h77, 1'b0);
         host_op(OP_STOP, 8'h00, 1'b0);
      end
      settle();
      check(8'(rxq.size()), 8'h00);
      $display("test mismatch done");
      // busy write cycle, then acknowledge polling
      nvm_busy <= 1'b1;
      host_op(OP_START, 8'h00, 1'b0);
      wr_byte(CTRL_WR, 1'b0);
      host_op(OP_STOP, 8'h00, 1'b0);
      nvm_busy <= 1'b0;
      settle();
      tx_idx <= 0;
      host_op(OP_START, 8'h00, 1'b0);
      wr_byte(CTRL_RD, 1'b1);
      rd_byte(1'b1, TBL[0]);
      host_op(OP_STOP, 8'h00, 1'b0);
      settle();
      $display("test busy done");
      final_report();
   end

endmodule : two_wire_slave_protocol_bench

`default_nettype wire
